// *** rtl/sasi_pkg.sv ***
// package: register map, field positions and reset values of the status/irq block
package sasi_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] SASI_OFS_CTRL        = 8'h00;
  localparam logic [7:0] SASI_OFS_CONFIG      = 8'h04;
  localparam logic [7:0] SASI_OFS_CH_EN_UPPER = 8'h08;
  localparam logic [7:0] SASI_OFS_CH_EN_LOWER = 8'h0c;
  localparam logic [7:0] SASI_OFS_STATUS      = 8'h10;
  localparam logic [7:0] SASI_OFS_IRQ_SET     = 8'h14;
  localparam logic [7:0] SASI_OFS_IRQ_CLR     = 8'h18;
  localparam logic [7:0] SASI_OFS_IRQ_MASK    = 8'h1c;
  localparam logic [7:0] SASI_OFS_FLAG_CLEAR  = 8'h20;
  // ****************************************
  // status field positions
  // ****************************************
  localparam int SASI_BIT_EXP     = 0;
  localparam int SASI_BIT_CAS     = 1;
  localparam int SASI_BIT_CAU     = 2;
  localparam int SASI_BIT_UNLOCK_PORT_READ  = 3;
  localparam int SASI_BIT_UNLOCK_KEY_ERROR   = 4;
  localparam int SASI_BIT_UNLOCK_WHILE_ERROR    = 5;
  localparam int SASI_BIT_MBERR   = 6;
  localparam int SASI_BIT_REMAP_ADDRESS_ERROR  = 7;
  localparam int SASI_BIT_ENABLED = 8;
  localparam int SASI_BIT_SETUP   = 9;
  localparam int SASI_BIT_IDLE    = 10;
  localparam int SASI_NUM_EVENTS  = 8;
  // ****************************************
  // reset values and remap page check
  // ****************************************
  localparam logic [31:0] SASI_RST_CH_EN  = 32'h0000_0000;
  localparam logic [31:0] SASI_RST_STATUS = 32'h0000_0400;
  localparam logic [7:0]  SASI_RST_MASK   = 8'h00;
  localparam logic [13:0] SASI_REMAP_PAGE = 14'h3fff;
endpackage : sasi_pkg

// *** rtl/sasi_status_irq.sv ***
// status flags, channel enables and interrupt mask of the secure access unit
`timescale 1ns/1ps
`default_nettype none

module sasi_status_irq #(
  parameter int NUM_CHANNELS = 64
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // register port
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  // unit state from the core
  input  wire logic        unit_enabled_in,
  input  wire logic        setup_mode_in,
  input  wire logic        chan_op_start_in,
  input  wire logic        chan_op_done_in,
  input  wire logic        bus_ops_pending_in,
  // event sources from the core
  input  wire logic        remap_target_wr_in,
  input  wire logic [31:0] remap_target_data_in,
  input  wire logic        master_bus_error_in,
  input  wire logic        unlock_port_wr_in,
  input  wire logic        unlock_key_match_in,
  input  wire logic        unlock_port_rd_in,
  input  wire logic        chan_access_in,
  input  wire logic [5:0]  chan_access_num_in,
  input  wire logic        chan_unlocked_in,
  input  wire logic        unlock_timeout_in,
  // outputs
  output logic [63:0]      channel_enable_out,
  output logic             chan_access_allowed_out,
  output logic             unlock_aborted_out,
  output logic             irq_out
);
  import sasi_pkg::*;

  // ****************************************
  // elaboration check
  // ****************************************
  // the access number is six bits wide: more channels could not be told apart
  generate
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 64) begin : g_bad_channels
      $error("NUM_CHANNELS must lie in 1..64");
    end
  endgenerate

  // ****************************************
  // state and internal signals
  // ****************************************
  // channel enables
  logic [31:0] ch_en_lower_reg;
  logic [31:0] ch_en_lower_next;
  logic [31:0] ch_en_upper_reg;
  logic [31:0] ch_en_upper_next;
  // event flags and interrupt mask
  logic [7:0]  events_reg;
  logic [7:0]  events_next;
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  // unit levels and idle tracking
  logic        enabled_reg;
  logic        enabled_next;
  logic        setup_reg;
  logic        setup_next;
  logic        idle_reg;
  logic        idle_next;
  logic        busy_reg;
  logic        busy_next;
  // read path
  logic [31:0] rdata_next;
  // write decode and event helpers
  logic        wr_ch_en_lower;
  logic        wr_ch_en_upper;
  logic        wr_irq_set;
  logic        wr_irq_clr;
  logic        wr_flag_clear;
  logic [7:0]  ev_set;
  logic [7:0]  ev_clr;
  logic [63:0] ch_en_all;
  logic        chan_enabled;
  logic        chan_granted;
  logic        any_error;

  // ****************************************
  // write decode
  // ****************************************
  // writes to read-only or unmapped offsets fall through and are dropped
  always_comb begin
    wr_ch_en_lower = 1'b0;
    wr_ch_en_upper = 1'b0;
    wr_irq_set     = 1'b0;
    wr_irq_clr     = 1'b0;
    wr_flag_clear  = 1'b0;
    if (reg_wr_in && reg_addr_in == SASI_OFS_CH_EN_LOWER) begin
      wr_ch_en_lower = 1'b1;
    end else if (reg_wr_in && reg_addr_in == SASI_OFS_CH_EN_UPPER) begin
      wr_ch_en_upper = 1'b1;
    end else if (reg_wr_in && reg_addr_in == SASI_OFS_IRQ_SET) begin
      wr_irq_set = 1'b1;
    end else if (reg_wr_in && reg_addr_in == SASI_OFS_IRQ_CLR) begin
      wr_irq_clr = 1'b1;
    end else if (reg_wr_in && reg_addr_in == SASI_OFS_FLAG_CLEAR) begin
      wr_flag_clear = 1'b1;
    end
  end

  // ****************************************
  // channel enables
  // ****************************************
  always_comb begin
    ch_en_lower_next = ch_en_lower_reg;
    ch_en_upper_next = ch_en_upper_reg;
    if (wr_ch_en_lower) begin
      ch_en_lower_next = reg_wdata_in;
    end
    if (wr_ch_en_upper) begin
      ch_en_upper_next = reg_wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ch_en_lower_reg <= SASI_RST_CH_EN;
      ch_en_upper_reg <= SASI_RST_CH_EN;
    end else begin
      ch_en_lower_reg <= ch_en_lower_next;
      ch_en_upper_reg <= ch_en_upper_next;
    end
  end

  assign ch_en_all = {ch_en_upper_reg, ch_en_lower_reg};

  // bits of absent channels read back but gate nothing
  genvar ch;
  generate
    for (ch = 0; ch < 64; ch++) begin : g_chan
      if (ch < NUM_CHANNELS) begin : g_present
        assign channel_enable_out[ch] = ch_en_all[ch];
      end else begin : g_absent
        assign channel_enable_out[ch] = 1'b0;
      end
    end
  endgenerate

  assign chan_enabled            = channel_enable_out[chan_access_num_in];
  assign chan_granted            = chan_enabled && chan_unlocked_in;
  assign chan_access_allowed_out = chan_granted;

  // ****************************************
  // event flags
  // ****************************************
  // error bits are every event except the three channel-outcome flags
  assign any_error          = |events_reg[SASI_BIT_REMAP_ADDRESS_ERROR:SASI_BIT_UNLOCK_PORT_READ];
  assign unlock_aborted_out = unlock_port_wr_in && any_error;

  always_comb begin
    ev_set = 8'h00;
    ev_set[SASI_BIT_REMAP_ADDRESS_ERROR] = setup_mode_in && remap_target_wr_in &&
                              (remap_target_data_in[31:18] != SASI_REMAP_PAGE);
    ev_set[SASI_BIT_MBERR]  = master_bus_error_in;
    ev_set[SASI_BIT_UNLOCK_WHILE_ERROR]   = unlock_port_wr_in && any_error;
    // an aborted unlock never checks the key
    ev_set[SASI_BIT_UNLOCK_KEY_ERROR]  = unlock_port_wr_in && !any_error && !unlock_key_match_in;
    ev_set[SASI_BIT_UNLOCK_PORT_READ] = unlock_port_rd_in;
    ev_set[SASI_BIT_CAU]    = chan_access_in && !chan_granted;
    ev_set[SASI_BIT_CAS]    = chan_access_in && chan_granted;
    // timeout only counts when no access ended the unlock in the same cycle
    ev_set[SASI_BIT_EXP]    = unlock_timeout_in && !chan_access_in;
    ev_clr = wr_flag_clear ? reg_wdata_in[SASI_NUM_EVENTS-1:0] : 8'h00;
    // a new event beats a clear in the same cycle, so no event is ever lost
    events_next = (events_reg & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      events_reg <= SASI_RST_STATUS[SASI_NUM_EVENTS-1:0];
    end else begin
      events_reg <= events_next;
    end
  end

  // ****************************************
  // interrupt mask and request
  // ****************************************
  always_comb begin
    mask_next = mask_reg;
    if (wr_irq_set) begin
      mask_next = mask_reg | reg_wdata_in[7:0];
    end else if (wr_irq_clr) begin
      mask_next = mask_reg & ~reg_wdata_in[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      mask_reg <= SASI_RST_MASK;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // level request: drops with the flag clear or the mask clear, no latch of its own
  assign irq_out = |(events_reg & mask_reg);

  // ****************************************
  // unit levels
  // ****************************************
  // these trail the core's levels by one cycle
  always_comb begin
    enabled_next = unit_enabled_in;
    setup_next   = setup_mode_in;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      enabled_reg <= SASI_RST_STATUS[SASI_BIT_ENABLED];
      setup_reg   <= SASI_RST_STATUS[SASI_BIT_SETUP];
    end else begin
      enabled_reg <= enabled_next;
      setup_reg   <= setup_next;
    end
  end

  // ****************************************
  // idle tracking
  // ****************************************
  always_comb begin
    busy_next = busy_reg;
    if (chan_op_start_in) begin
      busy_next = 1'b1;
    end else if (chan_op_done_in) begin
      busy_next = 1'b0;
    end
    // idle falls in the start cycle's edge, rises only with nothing pending
    idle_next = !chan_op_start_in && !busy_next && !bus_ops_pending_in;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      idle_reg <= SASI_RST_STATUS[SASI_BIT_IDLE];
      busy_reg <= 1'b0;
    end else begin
      idle_reg <= idle_next;
      busy_reg <= busy_next;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // read data holds between reads so a slow master may sample it late
  always_comb begin
    rdata_next = reg_rdata_out;
    if (reg_rd_in) begin
      rdata_next = 32'h0000_0000;
      if (reg_addr_in == SASI_OFS_CH_EN_LOWER) begin
        rdata_next = ch_en_lower_reg;
      end else if (reg_addr_in == SASI_OFS_CH_EN_UPPER) begin
        rdata_next = ch_en_upper_reg;
      end else if (reg_addr_in == SASI_OFS_STATUS) begin
        rdata_next[SASI_NUM_EVENTS-1:0] = events_reg;
        rdata_next[SASI_BIT_ENABLED]    = enabled_reg;
        rdata_next[SASI_BIT_SETUP]      = setup_reg;
        rdata_next[SASI_BIT_IDLE]       = idle_reg;
      end else if (reg_addr_in == SASI_OFS_IRQ_MASK) begin
        rdata_next[7:0] = mask_reg;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

endmodule : sasi_status_irq
`default_nettype wire

// *** verif/sasi_master_model.sv ***
// partner: bus master issuing one channel access after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module sasi_master_model (
  input  wire logic       clock_in, srst_in, req_in,
  input  wire logic [3:0] delay_in,
  input  wire logic [5:0] num_in,
  output logic            access_out,
  output logic      [5:0] num_out
);
  logic [4:0] cnt_reg;
  always_ff @(posedge clock_in) begin
    access_out <= 1'b0;
    num_out    <= ~num_out; // number is meaningless between accesses
    if (srst_in) begin
      cnt_reg <= 5'h00;
      num_out <= 6'h00;
    end else if (req_in) cnt_reg <= {1'b0, delay_in} + 5'h01;
    else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
      if (cnt_reg == 5'h01) begin
        access_out <= 1'b1;
        num_out    <= num_in;
      end
    end
  end
endmodule : sasi_master_model
`default_nettype wire

// *** verif/sasi_status_irq_checker.sv ***
// checker: port relations of the status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module sasi_status_irq_checker #(parameter int NUM_CHANNELS = 64) (
  input wire logic clock_in, srst_in, reg_wr_in, reg_rd_in, unit_enabled_in, setup_mode_in,
  input wire logic chan_op_start_in, chan_op_done_in, remap_target_wr_in, master_bus_error_in,
  input wire logic unlock_port_wr_in, unlock_port_rd_in, chan_access_in, unlock_timeout_in,
  input wire logic chan_access_allowed_out, unlock_aborted_out, irq_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in, reg_rdata_out,
  input wire logic [63:0] channel_enable_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  logic ev_any;
  assign ev_any = remap_target_wr_in | master_bus_error_in | unlock_port_wr_in
                | unlock_port_rd_in | chan_access_in | unlock_timeout_in;
  // helper: a bus error flag is standing (set wins over a clear in one cycle)
  logic mb_flag_reg;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      mb_flag_reg <= 1'b0;
    end else begin
      mb_flag_reg <= master_bus_error_in
                   | (mb_flag_reg & !(reg_wr_in && reg_addr_in == 8'h20 && reg_wdata_in[6]));
    end
  end
  // status read two edges after the cause, no write in between
  sequence s_rd2; !reg_wr_in ##1 (reg_rd_in && reg_addr_in == 8'h10); endsequence
  sequence s_st_rd; reg_rd_in && reg_addr_in == 8'h10 && !$past(srst_in); endsequence
  property p_low; reg_wr_in && reg_addr_in == 8'h0c |=> channel_enable_out[31:0] == $past(reg_wdata_in); endproperty
  a_low: assert property (p_low) else $error("lower enable mismatch");
  property p_up; reg_wr_in && reg_addr_in == 8'h08 |=> channel_enable_out[63:32] == $past(reg_wdata_in); endproperty
  a_up: assert property (p_up) else $error("upper enable mismatch");
  property p_idle; chan_op_start_in ##1 !chan_op_done_in ##1 (reg_rd_in && reg_addr_in == 8'h10) |=> !reg_rdata_out[10]; endproperty
  a_idle: assert property (p_idle) else $error("idle not dropped");
  property p_en; s_st_rd and (unit_enabled_in && $past(unit_enabled_in)) |=> reg_rdata_out[8]; endproperty
  a_en: assert property (p_en) else $error("enabled flag low");
  property p_su; s_st_rd and !(setup_mode_in || $past(setup_mode_in)) |=> !reg_rdata_out[9]; endproperty
  a_su: assert property (p_su) else $error("setup flag high");
  property p_cau; chan_access_in && !chan_access_allowed_out ##1 s_rd2 |=> reg_rdata_out[2]; endproperty
  a_cau: assert property (p_cau) else $error("access fail flag low");
  property p_urd; unlock_port_rd_in ##1 s_rd2 |=> reg_rdata_out[3]; endproperty
  a_urd: assert property (p_urd) else $error("unlock read flag low");
  property p_abt; unlock_aborted_out ##1 s_rd2 |=> reg_rdata_out[5]; endproperty
  a_abt: assert property (p_abt) else $error("abort flag low");
  property p_ier; mb_flag_reg && reg_wr_in && reg_addr_in == 8'h14 && reg_wdata_in[6] |=> irq_out; endproperty
  a_ier: assert property (p_ier) else $error("irq not raised");
  property p_idr; reg_wr_in && reg_addr_in == 8'h18 && reg_wdata_in[7:0] == 8'hff |=> !irq_out; endproperty
  a_idr: assert property (p_idr) else $error("irq after mask clear");
  property p_clr; reg_wr_in && reg_addr_in == 8'h20 && reg_wdata_in[7:0] == 8'hff && !ev_any |=> !irq_out; endproperty
  a_clr: assert property (p_clr) else $error("irq after flag clear");
endmodule : sasi_status_irq_checker
bind sasi_status_irq sasi_status_irq_checker #(.NUM_CHANNELS(NUM_CHANNELS)) chk_i (.clock_in,
  .srst_in, .reg_wr_in, .reg_rd_in, .unit_enabled_in, .setup_mode_in, .chan_op_start_in,
  .chan_op_done_in, .remap_target_wr_in, .master_bus_error_in, .unlock_port_wr_in,
  .unlock_port_rd_in, .chan_access_in, .unlock_timeout_in, .chan_access_allowed_out,
  .unlock_aborted_out, .irq_out, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .channel_enable_out);
`default_nettype wire

// *** verif/tb_sasi_status_irq.sv ***
// testbench: registers, status flags, mask and irq of the status block
`timescale 1ns/1ps
`default_nettype none
module tb_sasi_status_irq;
  logic clock_in = 0, srst_in = 1, wr = 0, rd = 0, en = 0, su = 0, pend = 0, km = 0, ul = 0;
  logic req = 0, acc, irq, alw, abo;
  logic [5:0] anum;
  logic [7:0] a = 0, e, m = 0;
  logic [9:0] ev = 0;
  logic [31:0] d = 0, rdat, rtd = 0, x = 0, seed = 32'hfd664c22;
  logic [7:0] zad [5] = '{8'h08, 8'h0c, 8'h14, 8'h1c, 8'h30};
  logic [63:0] chen;
  int fail_count = 0, cmp_count = 0;
  always #25 clock_in = ~clock_in;
  sasi_master_model pm (.clock_in, .srst_in, .req_in(req), .delay_in(x[8:5]),
    .num_in({1'b0, x[4:0]}), .access_out(acc), .num_out(anum));
  sasi_status_irq #(.NUM_CHANNELS(64)) dut (.clock_in, .srst_in, .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(a), .reg_wdata_in(d), .reg_rdata_out(rdat),
    .unit_enabled_in(en), .setup_mode_in(su), .chan_op_start_in(ev[9]),
    .chan_op_done_in(ev[8]), .bus_ops_pending_in(pend), .remap_target_wr_in(ev[7]),
    .remap_target_data_in(rtd), .master_bus_error_in(ev[6]), .unlock_port_wr_in(ev[5] | ev[4]),
    .unlock_key_match_in(km), .unlock_port_rd_in(ev[3]), .chan_access_in(acc),
    .chan_access_num_in(anum), .chan_unlocked_in(ul), .unlock_timeout_in(ev[0]),
    .channel_enable_out(chen), .chan_access_allowed_out(alw), .unlock_aborted_out(abo),
    .irq_out(irq));
  task automatic chk(input string n, input logic [63:0] ex, input logic [63:0] g);
    cmp_count++;
    if (g !== ex) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, ex, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clock_in) {wr, a, d} <= {1'b1, ad, dt};
    @(posedge clock_in) wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] ad, input logic [31:0] ex);
    @(posedge clock_in) {rd, a} <= {1'b1, ad};
    @(posedge clock_in) rd <= 1'b0;
    #1 chk("rdata", ex, rdat);
  endtask : rreg
  task automatic evp(input logic [9:0] v);
    @(posedge clock_in) ev <= v;
    @(posedge clock_in) ev <= 10'h000;
  endtask : evp
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge clock_in);
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    // enable and mask registers, write-only and unmapped places read zero after reset
    foreach (zad[i]) rreg(zad[i], 0);
    rreg(8'h10, 32'h400);
    $display("test reset done");
    repeat (8) begin
      x = $random(seed);
      wreg(8'h0c, x);
      wreg(8'h08, ~x);
      #1 chk("chen", {~x, x}, chen);
      rreg(8'h0c, x);
      wreg(8'h14, x);
      wreg(8'h18, x >> 8);
      m = (m | x[7:0]) & ~x[15:8];
      rreg(8'h1c, {24'h0, m});
    end
    $display("test enables done");
    @(posedge clock_in) {en, su} <= 2'b11;
    rreg(8'h10, 32'h700);
    evp(10'h200);
    rreg(8'h10, 32'h300);
    @(posedge clock_in) pend <= 1'b1;
    evp(10'h100);
    rreg(8'h10, 32'h300);
    @(posedge clock_in) pend <= 1'b0;
    evp(10'h100);
    rreg(8'h10, 32'h700);
    wreg(8'h0c, 32'hffffffff);
    wreg(8'h08, 32'hffffffff);
    wreg(8'h18, 32'hff);
    for (int i = 0; i < 8; i++) begin
      e = (i == 5) ? 8'h60 : 8'h01 << i;
      @(posedge clock_in) {km, ul, rtd} <= {i != 4, i == 1, 32'h0};
      #1 chk("allowed", i == 1, alw);
      if (i == 5) evp(10'h040);
      if (i == 1 || i == 2) begin
        @(posedge clock_in) {req, x} <= {1'b1, $random(seed)};
        @(posedge clock_in) req <= 1'b0;
        for (int k = 0; k < 20 && acc !== 1'b1; k++) @(negedge clock_in);
        @(posedge clock_in);
      end else begin
        @(posedge clock_in) ev <= 10'h001 << i;
        #1 chk("abort", i == 5, abo);
        @(posedge clock_in) ev <= 10'h000;
      end
      rreg(8'h10, {21'h0, 3'b111, e});
      wreg(8'h14, 32'hff);
      #1 chk("irq", 1, irq);
      wreg(8'h20, 32'hff);
      #1 chk("irq", 0, irq);
      rreg(8'h10, 32'h700);
    end
    @(posedge clock_in) rtd <= {14'h3fff, x[17:0]};
    evp(10'h080);
    rreg(8'h10, 32'h700);
    @(posedge clock_in) {en, su} <= 2'b00;
    rreg(8'h10, 32'h400);
    $display("test events done");
    end_sim;
  end
endmodule : tb_sasi_status_irq
`default_nettype wire
